// ---- hdl/ecs_pkg.sv ----
/*
 Package for the expander clock select and loss monitor.
 Holds timing constants, counts and the sequencer state type.
 Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package ecs_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int OSC_FREQ_MHZ = 8;
   localparam int LINK_FREQ_MHZ = 8;
   localparam int OSC_PERIOD_NS = 1000 / OSC_FREQ_MHZ;
   // Startup sequence length in internal oscillator cycles.
   localparam int STARTUP_CYCLES = 64;
   // Loss is declared after this many oscillator cycles with no link edge.
   localparam int LOSS_LIMIT_CYCLES = 16;
   localparam int CNT_W = 8;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic RST_N_RESET = 1'b0;
   localparam logic CLK_OUT_EN_RESET = 1'b0;
   localparam logic [7:0] SAFE_OUT_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ECS_STARTUP,
      ECS_RUN_LINK,
      ECS_LOST
   } ecs_state_t;

endpackage : ecs_pkg

// ---- hdl/ecs_edge_sense.sv ----
/*
 Link-side activity detector for the expander clock monitor.
 Runs on the link write clock and flips a toggle on every rising edge.
 Takes its reset from the oscillator domain through two flops of its own.
 Assumes the consumer re-synchronises the toggle into its own domain.
*/
`timescale 1ns/10ps
`default_nettype none

module ecs_edge_sense
   import ecs_pkg::*;
(
   input wire logic i_link_clk,
   input wire logic i_rst_link,
   output logic o_toggle
);

   typedef struct packed {
      logic [1:0] rst_sync;
      logic toggle;
   } ecs_edge_t;

   ecs_edge_t st_q;
   ecs_edge_t st_d;

   // Reset comes from the oscillator domain, so it is retimed here first.
   // Without it the toggle would never leave its unknown start value.
   // While the link clock is stopped the toggle simply freezes.
   always_comb begin
      st_d = st_q;
      st_d.rst_sync = {st_q.rst_sync[0], i_rst_link};
      st_d.toggle = st_q.rst_sync[1] ? 1'b0 : ~st_q.toggle;
   end

   always_ff @(posedge i_link_clk) begin
      st_q <= st_d;
   end

   assign o_toggle = st_q.toggle;

endmodule : ecs_edge_sense

`default_nettype wire

// ---- hdl/ecs_clock_monitor.sv ----
/*
 Expander clock select and link clock loss monitor.
 Runs on the internal oscillator clock I_CLK; watches the link write clock,
 selects the operating clock source and drives reset and safe state.
 Assumes the controller supplies the link write clock and declares any
 external source; the clock output pin is kept disabled.
*/
`timescale 1ns/10ps
`default_nettype none

module ecs_clock_monitor
   import ecs_pkg::*;
#(
   parameter int STARTUP_LEN = STARTUP_CYCLES,
   parameter int LOSS_LIMIT = LOSS_LIMIT_CYCLES,
   parameter int OUT_W = 8
) (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_LINK_WRITE_CLOCK,
   input wire logic I_MANDATORY,
   input wire logic I_EXT_CLOCK_SEL,
   input wire logic [OUT_W-1:0] I_USER_OUT,
   output logic O_EXPANDER_RESET_N_OUT,
   output logic O_EXPANDER_RESET_N_OE,
   output logic O_EXPANDER_CLOCK_OUT,
   output logic O_EXPANDER_CLOCK_OUT_OE,
   output logic O_USE_LINK_CLOCK,
   output logic O_LINK_LOSS,
   output logic [OUT_W-1:0] O_SAFE_OUT
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      ecs_state_t state;
      logic [CNT_W-1:0] start_cnt;
      logic [CNT_W-1:0] idle_cnt;
      logic [2:0] tog_sync;
      logic [1:0] mand_sync;
      logic [1:0] ext_sync;
      logic rst_n;
      logic rst_oe;
      logic use_link;
      logic loss;
      logic [OUT_W-1:0] outs;
      logic clk_out;
      logic clk_oe;
   } ecs_state_vec_t;

   ecs_state_vec_t st_q;
   ecs_state_vec_t st_d;
   logic link_toggle;
   logic link_rst;

   // The link side retimes this reset into its own clock; a stopped link
   // clock simply leaves the toggle frozen, which is what loss looks like.
   assign link_rst = I_RST;

   ecs_edge_sense u_edge (
      .i_link_clk(I_LINK_WRITE_CLOCK),
      .i_rst_link(link_rst),
      .o_toggle(link_toggle)
   );

   function automatic logic [CNT_W-1:0] inc_sat(
      input logic [CNT_W-1:0] v
   );
      inc_sat = (v == {CNT_W{1'b1}}) ? v : v + CNT_W'(1);
   endfunction : inc_sat

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      logic edge_seen;
      edge_seen = 1'b0;
      st_d = st_q;
      st_d.tog_sync = {st_q.tog_sync[1:0], link_toggle};
      st_d.mand_sync = {st_q.mand_sync[0], I_MANDATORY};
      st_d.ext_sync = {st_q.ext_sync[0], I_EXT_CLOCK_SEL};
      edge_seen = st_q.tog_sync[2] ^ st_q.tog_sync[1];
      // Outputs sit in the safe state everywhere but the run state.
      st_d.outs = OUT_W'(SAFE_OUT_RESET);
      // Clock output pin is never driven, whatever the source.
      st_d.clk_out = 1'b0;
      st_d.clk_oe = CLK_OUT_EN_RESET;
      // Idle count runs in every state so loss is visible early.
      st_d.idle_cnt = edge_seen ? '0 : inc_sat(st_q.idle_cnt);
      case (st_q.state)
         ECS_STARTUP: begin
            st_d.use_link = 1'b0;
            st_d.rst_n = RST_N_RESET;
            st_d.rst_oe = 1'b1;
            st_d.start_cnt = inc_sat(st_q.start_cnt);
            if (st_q.start_cnt >= CNT_W'(STARTUP_LEN - 1) &&
                st_q.idle_cnt < CNT_W'(LOSS_LIMIT)) begin
               st_d.state = ECS_RUN_LINK;
               st_d.use_link = 1'b1;
               st_d.rst_n = 1'b1;
               st_d.rst_oe = 1'b0;
            end
         end
         ECS_RUN_LINK: begin
            st_d.outs = I_USER_OUT;
            if (st_q.idle_cnt >= CNT_W'(LOSS_LIMIT)) begin
               st_d.state = ECS_LOST;
               st_d.loss = 1'b1;
               st_d.use_link = 1'b0;
               st_d.rst_n = RST_N_RESET;
               st_d.rst_oe = 1'b1;
               st_d.outs = OUT_W'(SAFE_OUT_RESET);
               st_d.start_cnt = '0;
            end
         end
         ECS_LOST: begin
            st_d.outs = OUT_W'(SAFE_OUT_RESET);
            st_d.use_link = 1'b0;
            st_d.rst_n = RST_N_RESET;
            // Mandatory and optional expanders alike hold the line for as long
            // as the fault lasts; I_MANDATORY does not change what happens here.
            st_d.rst_oe = 1'b1;
            if (st_q.idle_cnt < CNT_W'(LOSS_LIMIT) && !st_q.mand_sync[1])
            begin
               st_d.state = ECS_STARTUP;
               st_d.loss = 1'b0;
            end else if (st_q.idle_cnt < CNT_W'(LOSS_LIMIT)) begin
               st_d.state = ECS_STARTUP;
               st_d.loss = 1'b0;
            end
         end
         default: begin
            st_d.state = ECS_STARTUP;
         end
      endcase
      if (st_q.state == ECS_LOST && st_d.state == ECS_LOST) begin
         st_d.rst_n = RST_N_RESET;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         st_q <= '0;
         st_q.state <= ECS_STARTUP;
         st_q.rst_n <= RST_N_RESET;
         st_q.rst_oe <= 1'b1;
         st_q.outs <= OUT_W'(SAFE_OUT_RESET);
         st_q.clk_oe <= CLK_OUT_EN_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign O_EXPANDER_CLOCK_OUT = st_q.clk_out;
   assign O_EXPANDER_CLOCK_OUT_OE = st_q.clk_oe;
   assign O_EXPANDER_RESET_N_OUT = st_q.rst_n;
   assign O_EXPANDER_RESET_N_OE = st_q.rst_oe;
   assign O_USE_LINK_CLOCK = st_q.use_link;
   assign O_LINK_LOSS = st_q.loss;
   assign O_SAFE_OUT = st_q.outs;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_loss_seen;
      st_q.state == ECS_RUN_LINK && st_q.idle_cnt >= CNT_W'(LOSS_LIMIT);
   endsequence

   sequence s_lost_state;
      st_q.state == ECS_LOST && !O_EXPANDER_RESET_N_OUT;
   endsequence

   property p_no_link_in_startup;
      @(posedge I_CLK) disable iff (I_RST)
      st_q.state == ECS_STARTUP |-> !O_USE_LINK_CLOCK;
   endproperty
   a_no_link_in_startup: assert property (p_no_link_in_startup)
      else $error("link clock used during startup");

   property p_switch_after_start;
      @(posedge I_CLK) disable iff (I_RST)
      $rose(O_USE_LINK_CLOCK) |-> $past(st_q.state) == ECS_STARTUP;
   endproperty
   a_switch_after_start: assert property (p_switch_after_start)
      else $error("switch to link clock without startup");

   property p_loss_reset;
      @(posedge I_CLK) disable iff (I_RST)
      s_loss_seen |=> s_lost_state ##0 O_EXPANDER_RESET_N_OE;
   endproperty
   a_loss_reset: assert property (p_loss_reset)
      else $error("loss did not pull reset low");

   property p_safe_out;
      @(posedge I_CLK) disable iff (I_RST)
      s_loss_seen |=> (O_SAFE_OUT == OUT_W'(SAFE_OUT_RESET)) [*2];
   endproperty
   a_safe_out: assert property (p_safe_out)
      else $error("outputs not in safe state after loss");

   property p_clk_out_off;
      @(posedge I_CLK) disable iff (I_RST)
      ##1 !O_EXPANDER_CLOCK_OUT_OE && !O_EXPANDER_CLOCK_OUT;
   endproperty
   a_clk_out_off: assert property (p_clk_out_off)
      else $error("clock output pin driven");

   property p_ext_off;
      @(posedge I_CLK) disable iff (I_RST)
      st_q.ext_sync[1] |-> !O_EXPANDER_CLOCK_OUT_OE;
   endproperty
   a_ext_off: assert property (p_ext_off)
      else $error("clock output enabled with external source");

   property p_hold_reset;
      @(posedge I_CLK) disable iff (I_RST)
      st_q.state == ECS_LOST |-> !O_EXPANDER_RESET_N_OUT &&
         O_EXPANDER_RESET_N_OE;
   endproperty
   a_hold_reset: assert property (p_hold_reset)
      else $error("reset line released during fault");

   property p_loss_limit;
      @(posedge I_CLK) disable iff (I_RST)
      st_q.state == ECS_RUN_LINK && st_q.idle_cnt < CNT_W'(LOSS_LIMIT)
      |=> st_q.state != ECS_LOST;
   endproperty
   a_loss_limit: assert property (p_loss_limit)
      else $error("loss declared before limit");

endmodule : ecs_clock_monitor

`default_nettype wire

// ---- dv/ecs_link_src.sv ----
/*
 Behavioural controller side: the source of the link write clock.
 Assumes the bench gates it; it stands low whenever it is not running.
*/
`timescale 1ns/10ps
`default_nettype none

module ecs_link_src #(
   parameter real HALF_NS = 16.0
) (
   input wire logic i_run,
   output logic o_link_clk
);
   // The phase offset keeps this clock unrelated to the oscillator clock.
   initial begin
      o_link_clk = 1'b0;
      #7;
      forever begin
         #(HALF_NS);
         o_link_clk = i_run ? ~o_link_clk : 1'b0;
      end
   end
endmodule : ecs_link_src

`default_nettype wire

// ---- dv/expander_clock_select_loss_monitor_tb.sv ----
/*
 Self-checking bench for the expander clock monitor.
 Assumes the design package and the link clock source model are compiled.
*/
`timescale 1ns/10ps
`default_nettype none

module expander_clock_select_loss_monitor_tb;
   import ecs_pkg::*;
   localparam int SLEN = 8;
   localparam int LLIM = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic run = 1'b1;
   logic mand = 1'b0;
   logic ext = 1'b0;
   logic [7:0] uout = 8'ha5;
   logic link_clk;
   logic rn, rn_oe, ck, ck_oe, use_l, loss;
   logic [7:0] sout;
   int n_errors = 0;
   int n_tests = 0;

   always #25 clk = ~clk;

   ecs_link_src i_ecs_link_src (.i_run(run), .o_link_clk(link_clk));

   ecs_clock_monitor #(.STARTUP_LEN(SLEN), .LOSS_LIMIT(LLIM), .OUT_W(8))
   i_ecs_clock_monitor (
      .I_CLK(clk), .I_RST(rst), .I_LINK_WRITE_CLOCK(link_clk),
      .I_MANDATORY(mand), .I_EXT_CLOCK_SEL(ext), .I_USER_OUT(uout),
      .O_EXPANDER_RESET_N_OUT(rn), .O_EXPANDER_RESET_N_OE(rn_oe),
      .O_EXPANDER_CLOCK_OUT(ck), .O_EXPANDER_CLOCK_OUT_OE(ck_oe),
      .O_USE_LINK_CLOCK(use_l), .O_LINK_LOSS(loss), .O_SAFE_OUT(sout)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task conclude();
      $display("tests %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   task chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : chk

   task held(input string m);
      chk(rn === 1'b0 && rn_oe === 1'b1 && sout === 8'h00 &&
          use_l === 1'b0 && ck_oe === 1'b0, m);
   endtask : held

   // Bounded wait for the run state or the loss state.
   task wait_hi(input logic on_loss, input int lim);
      for (int i = 0; i < lim; i++) begin
         if ((on_loss ? loss : use_l) === 1'b1) break;
         @(negedge clk);
      end
      if ((on_loss ? loss : use_l) !== 1'b1) begin
         chk(1'b0, "wait ran out");
         conclude();
      end
   endtask : wait_hi

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task test_startup();
      repeat (12) @(negedge clk);
      held("reset values");
      rst = 1'b0;
      repeat (SLEN - 2) @(negedge clk);
      held("switched before startup ended");
      wait_hi(1'b0, 20);
      // User outputs follow one cycle after the run state is entered.
      @(negedge clk);
      chk(rn === 1'b1 && rn_oe === 1'b0 && sout === uout, "run");
      chk(ck === 1'b0 && ck_oe === 1'b0 && loss === 1'b0, "clk pin");
      $display("test startup done");
   endtask : test_startup

   task test_loss(input logic m);
      mand = m;
      uout = m ? 8'hc3 : 8'h3c;
      repeat (3) @(negedge clk);
      chk(sout === uout, "user outputs not passed");
      run = 1'b0;
      repeat (2) @(negedge clk);
      chk(loss === 1'b0 && use_l === 1'b1, "early loss");
      wait_hi(1'b1, LLIM + 10);
      held("no safe state on loss");
      repeat (20) @(negedge clk);
      chk(loss === 1'b1 && rn === 1'b0, "loss not held");
      run = 1'b1;
      wait_hi(1'b0, SLEN + 30);
      @(negedge clk);
      chk(loss === 1'b0 && rn === 1'b1 && sout === uout, "recover");
      $display("test loss done");
   endtask : test_loss

   task test_refuse();
      rst = 1'b1;
      run = 1'b0;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (SLEN + 15) @(negedge clk);
      chk(use_l === 1'b0 && rn === 1'b0 && sout === 8'h00, "no link");
      run = 1'b1;
      wait_hi(1'b0, SLEN + 30);
      $display("test refuse done");
   endtask : test_refuse

   task test_ext();
      ext = 1'b1;
      repeat (10) @(negedge clk);
      chk(ck_oe === 1'b0 && ck === 1'b0 && use_l === 1'b1, "ext");
      ext = 1'b0;
      $display("test ext done");
   endtask : test_ext

   initial begin
      test_startup();
      test_loss(1'b0);
      test_loss(1'b1);
      test_refuse();
      test_ext();
      conclude();
   end
endmodule : expander_clock_select_loss_monitor_tb

`default_nettype wire
